// ---- src/pcwl_pkg.sv ----
// Constants for the per-port configuration word loader.
package pcwl_pkg;
  localparam int PCWL_PORTS = 6;
  localparam int PCWL_ACK_PORTS = 3;
  localparam int PCWL_AW = 8;
  localparam int PCWL_DW = 16;
  localparam int PCWL_RW = 32;
  // Group bases of the configuration word address space
  localparam logic [7:0] PCWL_LO_BASE = 8'hB0;
  localparam logic [7:0] PCWL_HI_BASE = 8'hC0;
  localparam logic [7:0] PCWL_RPL_BASE = 8'hD0;
  localparam logic [7:0] PCWL_ACK_BASE = 8'hE0;
  localparam int PCWL_LO_FIRST_PORT = 1;
  // Target register offsets inside a port
  localparam logic [7:0] PCWL_OFS_TIMER = 8'h70;
  localparam logic [7:0] PCWL_OFS_CTL = 8'h80;
  localparam logic [7:0] PCWL_OFS_PHY = 8'h8C;
  // Field positions
  localparam int PCWL_RPL_CNT_MSB = 11;
  localparam int PCWL_RPL_EN_BIT = 12;
  localparam int PCWL_TS_SRC_LSB = 13;
  localparam int PCWL_TS_SRC_MSB = 14;
  localparam int PCWL_TS_DST_LSB = 24;
  localparam int PCWL_TS_DST_MSB = 25;
  localparam int PCWL_ACK_SRC_MSB = 13;
  localparam int PCWL_ACK_EN_SRC = 14;
  localparam int PCWL_ACK_DST_LSB = 16;
  localparam int PCWL_ACK_DST_MSB = 29;
  localparam int PCWL_ACK_EN_DST = 30;
  // Reset values
  localparam logic [31:0] PCWL_TIMER_RST = 32'h0000_0000;
  localparam logic [31:0] PCWL_CTL_RST = 32'h0000_0000;
  localparam logic [31:0] PCWL_PHY_RST = 32'h0000_0000;
  localparam logic [15:0] PCWL_RD_NONE = 16'h0000;
endpackage : pcwl_pkg

// ---- src/pcwl_loader.sv ----
// Configuration word loader for the per-port registers of a six-port switch.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module pcwl_loader
  import pcwl_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [PCWL_AW-1:0] cfg_addr,
  input wire logic [PCWL_DW-1:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [PCWL_DW-1:0] cfg_rdata,
  input wire logic load_done,
  output logic cfg_loaded,
  output logic [PCWL_PORTS-1:0][PCWL_RW-1:0] port_timer,
  output logic [PCWL_PORTS-1:0][PCWL_RW-1:0] port_phy_control_word3,
  output logic [PCWL_PORTS-1:0][PCWL_RW-1:0] port_phy_ctl6
);

  // Staged copies collect the words; the ports only ever see the committed copies
  logic [PCWL_PORTS-1:0][PCWL_RW-1:0] ctl_reg;
  logic [PCWL_PORTS-1:0][PCWL_RW-1:0] ctl_next;
  logic [PCWL_PORTS-1:0][PCWL_RW-1:0] timer_reg;
  logic [PCWL_PORTS-1:0][PCWL_RW-1:0] timer_next;
  logic [PCWL_PORTS-1:0][PCWL_RW-1:0] phy_reg;
  logic [PCWL_PORTS-1:0][PCWL_RW-1:0] phy_next;

  // Committed copies seen by the ports
  logic [PCWL_PORTS-1:0][PCWL_RW-1:0] ctl_out_reg;
  logic [PCWL_PORTS-1:0][PCWL_RW-1:0] timer_out_reg;
  logic [PCWL_PORTS-1:0][PCWL_RW-1:0] phy_out_reg;

  // Read path and load status
  logic [PCWL_PORTS-1:0][PCWL_DW-1:0] rd_word;
  logic [PCWL_DW-1:0] rdata_reg;
  logic [PCWL_DW-1:0] rdata_next;
  logic [PCWL_DW-1:0] rdata_sel;
  logic loaded_reg;
  logic loaded_next;

  // Fields of the incoming word, named once for all ports
  wire [PCWL_DW-1:0] word_full = cfg_wdata;
  wire [PCWL_RPL_EN_BIT:0] word_rpl = cfg_wdata[PCWL_RPL_EN_BIT:0];
  wire [PCWL_TS_SRC_MSB-PCWL_TS_SRC_LSB:0] word_ts = cfg_wdata[PCWL_TS_SRC_MSB:PCWL_TS_SRC_LSB];
  wire [PCWL_ACK_EN_SRC:0] word_ack = cfg_wdata[PCWL_ACK_EN_SRC:0];

  genvar p;
  generate
    for (p = 0; p < PCWL_PORTS; p++) begin : g_port
      localparam logic [7:0] STEP = 8'(2 * p);
      localparam logic [7:0] LO_ADDR = PCWL_LO_BASE + STEP;
      localparam logic [7:0] HI_ADDR = PCWL_HI_BASE + STEP;
      localparam logic [7:0] RPL_ADDR = PCWL_RPL_BASE + STEP;
      localparam logic [7:0] ACK_ADDR = PCWL_ACK_BASE + STEP;
      // Port 0 has no lower control word here, ports above 2 no latency word
      localparam bit HAS_LO = (p >= PCWL_LO_FIRST_PORT);
      localparam bit HAS_ACK = (p < PCWL_ACK_PORTS);

      // Address decode, base plus twice the port number
      wire hit_lo = HAS_LO && (cfg_addr == LO_ADDR);
      wire hit_hi = (cfg_addr == HI_ADDR);
      wire hit_rpl = (cfg_addr == RPL_ADDR);
      wire hit_ack = HAS_ACK && (cfg_addr == ACK_ADDR);

      wire wr_lo = cfg_wr && hit_lo;
      wire wr_hi = cfg_wr && hit_hi;
      wire wr_rpl = cfg_wr && hit_rpl;
      wire wr_ack = cfg_wr && hit_ack;

      // Merged images; fields outside the word keep their staged value
      wire [PCWL_RW-1:0] ctl_lo_w = {ctl_reg[p][PCWL_RW-1:PCWL_DW], word_full};
      wire [PCWL_RW-1:0] ctl_hi_w = {word_full, ctl_reg[p][PCWL_DW-1:0]};
      wire [PCWL_RW-1:0] tmr_rpl_w = {timer_reg[p][PCWL_RW-1:PCWL_RPL_EN_BIT+1],
                                      word_rpl};
      wire [PCWL_RW-1:0] tmr_ack_w = {timer_reg[p][PCWL_RW-1:PCWL_ACK_EN_DST+1],
                                      word_ack,
                                      timer_reg[p][PCWL_ACK_DST_LSB-1:0]};
      wire [PCWL_RW-1:0] phy_rpl_w = {phy_reg[p][PCWL_RW-1:PCWL_TS_DST_MSB+1],
                                      word_ts,
                                      phy_reg[p][PCWL_TS_DST_LSB-1:0]};

      assign ctl_next[p] = wr_lo ? ctl_lo_w :
                           wr_hi ? ctl_hi_w :
                           ctl_reg[p];
      assign timer_next[p] = wr_rpl ? tmr_rpl_w :
                             wr_ack ? tmr_ack_w :
                             timer_reg[p];
      assign phy_next[p] = wr_rpl ? phy_rpl_w : phy_reg[p];

      // Read back rebuilds the word from the staged fields; bit 15 of timer words reads zero
      wire [PCWL_DW-1:0] rpl_rd = {1'b0,
                                   phy_reg[p][PCWL_TS_DST_MSB:PCWL_TS_DST_LSB],
                                   timer_reg[p][PCWL_RPL_EN_BIT:0]};
      wire [PCWL_DW-1:0] ack_rd = {1'b0, timer_reg[p][PCWL_ACK_EN_DST:PCWL_ACK_DST_LSB]};

      assign rd_word[p] = hit_lo ? ctl_reg[p][PCWL_DW-1:0] :
                          hit_hi ? ctl_reg[p][PCWL_RW-1:PCWL_DW] :
                          hit_rpl ? rpl_rd :
                          hit_ack ? ack_rd :
                          PCWL_RD_NONE;
    end
  endgenerate

  // Addresses are distinct per port, so at most one word is non-zero
  always_comb begin
    rdata_next = PCWL_RD_NONE;
    for (int i = 0; i < PCWL_PORTS; i++) begin
      rdata_next = rdata_next | rd_word[i];
    end
  end

  // Idle read data is zero, so a stale word never lingers on the bus
  assign rdata_sel = cfg_rd ? rdata_next : PCWL_RD_NONE;
  assign loaded_next = loaded_reg | load_done;

  // Staged control words
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PCWL_PORTS; i++) begin
        ctl_reg[i] <= PCWL_CTL_RST;
      end
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // Staged timer words
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PCWL_PORTS; i++) begin
        timer_reg[i] <= PCWL_TIMER_RST;
      end
    end else begin
      timer_reg <= timer_next;
    end
  end

  // Staged link control words
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PCWL_PORTS; i++) begin
        phy_reg[i] <= PCWL_PHY_RST;
      end
    end else begin
      phy_reg <= phy_next;
    end
  end

  // Commit on finish only, so a half-loaded port never sees mixed fields;
  // a word written in the commit cycle is included
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PCWL_PORTS; i++) begin
        ctl_out_reg[i] <= PCWL_CTL_RST;
      end
    end else if (load_done) begin
      ctl_out_reg <= ctl_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PCWL_PORTS; i++) begin
        timer_out_reg[i] <= PCWL_TIMER_RST;
      end
    end else if (load_done) begin
      timer_out_reg <= timer_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PCWL_PORTS; i++) begin
        phy_out_reg[i] <= PCWL_PHY_RST;
      end
    end else if (load_done) begin
      phy_out_reg <= phy_next;
    end
  end

  // Read data register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= PCWL_RD_NONE;
    end else begin
      rdata_reg <= rdata_sel;
    end
  end

  // Load status; stays set until reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= loaded_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_loaded = loaded_reg;
  assign port_timer = timer_out_reg;
  assign port_phy_control_word3 = ctl_out_reg;
  assign port_phy_ctl6 = phy_out_reg;

endmodule : pcwl_loader

// ---- test/pcwl_asserts.sv ----
// Checker on the loader's word port and commit outputs.
`timescale 1ns/1ps
module pcwl_asserts (input wire logic clock, rst, cfg_wr, cfg_rd, load_done, cfg_loaded,
  input wire logic [7:0] cfg_addr, input wire logic [15:0] cfg_wdata, cfg_rdata,
  input wire logic [5:0][31:0] port_timer, port_phy_ctl6);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire w16 = !cfg_addr[0] && cfg_addr inside {[8'hB2:8'hBA], [8'hC0:8'hCA]};
  wire w15 = !cfg_addr[0] && cfg_addr inside {[8'hD0:8'hDA], [8'hE0:8'hE4]};
  AST_RB16: assert property (cfg_wr && w16 ##1 cfg_rd && $stable(cfg_addr)
    |=> cfg_rdata == $past(cfg_wdata, 2)) else $error("rb16");
  AST_RB15: assert property (cfg_wr && w15 ##1 cfg_rd && $stable(cfg_addr)
    |=> cfg_rdata == ($past(cfg_wdata, 2) & 16'h7FFF)) else $error("rb15");
  AST_REF: assert property (cfg_rd && !w16 && !w15 |=> cfg_rdata == 16'h0000) else $error("ref");
  AST_IDLE: assert property (!cfg_rd |=> cfg_rdata == 16'h0000) else $error("idle");
  AST_HOLD: assert property (!load_done |=> $stable({port_timer, port_phy_ctl6})) else $error("hold");
  AST_DONE: assert property (load_done |=> cfg_loaded) else $error("done");
  AST_EARLY: assert property (!cfg_loaded && !load_done |=> !cfg_loaded) else $error("early");
  AST_BITS: assert property (port_phy_ctl6[2][23:0] == 24'h000000) else $error("bits");
endmodule : pcwl_asserts

// ---- test/pcwl_src.sv ----
// Word source model driving the loader's word port.
`timescale 1ns/1ps
module pcwl_src (input wire logic clock, input wire logic [15:0] cfg_rdata, output logic [7:0] cfg_addr = 8'h00,
  output logic [15:0] cfg_wdata = 16'h0000, output logic cfg_wr = 1'b0, cfg_rd = 1'b0, load_done = 1'b0);
  // Kind bits: write, read, commit; a commit may share a write's cycle
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, input logic [2:0] k, output logic [15:0] q);
    cfg_addr <= a;
    cfg_wdata <= d;
    {cfg_wr, cfg_rd, load_done} <= k;
    @(posedge clock);
    {cfg_wr, cfg_rd, load_done, cfg_wdata} <= {3'b000, ~d};
    #1 q = cfg_rdata;
  endtask : xfer
endmodule : pcwl_src

// ---- test/pcwl_loader_tb_top.sv ----
// Bench for the configuration word loader.
`timescale 1ns/1ps
module pcwl_loader_tb_top import pcwl_pkg::*; ();
  logic clock = 1'b0, rst = 1'b1, cfg_wr, cfg_rd, load_done, cfg_loaded;
  logic [7:0] cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata, q, ex [4][6] = '{default: 16'h0000};
  logic [5:0][31:0] port_timer, port_phy_control_word3, port_phy_ctl6;
  int err_count = 0, checks = 0;
  always #12.5 clock = ~clock;
  pcwl_src src (.clock, .cfg_rdata, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .load_done);
  pcwl_loader uut (.clock, .rst, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata, .load_done, .cfg_loaded,
    .port_timer, .port_phy_control_word3, .port_phy_ctl6);
  task automatic final_report();
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [95:0] g, input logic [95:0] e);
    checks++;
    err_count += int'(g !== e);
    if (g !== e) $display("unexpected %0t %h %h", $time, g, e);
  endtask : cmp
  task automatic ports();
    for (int p = 0; p < 6; p++)
      cmp({port_phy_control_word3[p], port_timer[p], port_phy_ctl6[p]}, {ex[1][p], ex[0][p],
        1'b0, ex[3][p][14:0], 3'h0, ex[2][p][12:0], 6'h00, ex[2][p][14:13], 24'h000000});
  endtask : ports
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 ports();
    for (int g = 0; g < 4; g++)
      for (int p = g == 0; p < (g == 3 ? 3 : 6); p++) begin
        ex[g][p] = 16'hE6A5 + 16'(g * 16 + p);
        src.xfer(8'(PCWL_LO_BASE + 16 * g + 2 * p), ex[g][p], 3'b100, q);
        src.xfer(8'(PCWL_LO_BASE + 16 * g + 2 * p), 16'h0000, 3'b010, q);
        cmp(q, ex[g][p] & (g < 2 ? 16'hFFFF : 16'h7FFF));
      end
    cmp(port_timer[0], 32'h0000_0000);
    cmp(cfg_loaded, 1'b0);
    src.xfer(8'hD3, 16'hFFFF, 3'b100, q);
    src.xfer(8'hE6, 16'hFFFF, 3'b010, q);
    cmp(q, 16'h0000);
    // Refused word and commit in one cycle
    src.xfer(8'hB0, 16'hFFFF, 3'b101, q);
    ports();
    cmp(cfg_loaded, 1'b1);
    ex[2][1] = 16'h0000;
    src.xfer(8'hD2, 16'h0000, 3'b101, q);
    ports();
    final_report();
  end
endmodule : pcwl_loader_tb_top
bind pcwl_loader pcwl_asserts chk (.clock, .rst, .cfg_wr, .cfg_rd, .load_done, .cfg_loaded, .cfg_addr,
  .cfg_wdata, .cfg_rdata, .port_timer, .port_phy_ctl6);
